// >>> backup_ram.v
// retained word memory of the always-on domain
`timescale 1ns/1ns
`include "backup_seconds_counter_consts.vh"

module backup_ram #(
  parameter DEPTH  = `RAM_DEPTH,
  parameter IDX_W  = `RAM_IDX_W
) (
  // clock
  input  wire             clk,
  // write port
  input  wire             we,
  input  wire [IDX_W-1:0] waddr,
  input  wire [31:0]      wdata,
  // read port, combinational so the caller can register it
  input  wire [IDX_W-1:0] raddr,
  output wire [31:0]      rdata
);

  // no reset on purpose: contents must survive a reset of the bus side
  reg [31:0] mem [0:DEPTH-1];

  // word write
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = mem[raddr];

endmodule

// >>> backup_seconds_counter.v
// backup-domain real-time seconds counter with apb register access
`timescale 1ns/1ns
`include "backup_seconds_counter_consts.vh"

// Function
// - 47-bit counter advances once per 32.768 kHz cycle while enabled
// - upper 32 bits are whole seconds, lower 15 bits are fraction
// - seconds and fraction are read at separate register addresses
// - clearing the enable bit stops the count; it holds until re-enabled or loaded
// - 32-bit writable seconds preload register
// - 15-bit writable fraction preload register
// - load bit copies both preloads into the counter in one update
// - hardware clears the load bit once the counter took the value
// - wake-up request raised when the count reaches the alarm time
// - programmable trimming compensates crystal frequency error
// - keeps counting independent of bus activity, always-on domain only
// - 256-byte retained memory in the always-on domain
// - registers reached as an apb slave on the always-on bridge
module backup_seconds_counter #(
  parameter TRIM_W = `TRIM_W
) (
  // clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // 32.768 kHz crystal clock, asynchronous to clk
  input  wire        xtal_32k,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [9:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // wake-up request to the system
  output reg         wake_req
);

  // true when the address falls in the backup memory window
  function is_ram;
    input [9:0] a;
    begin
      is_ram = (a[9:`RAM_BASE_BIT] == 2'b01);
    end
  endfunction

  // true when the address names one of the control registers
  function is_reg;
    input [9:0] a;
    begin
      is_reg = (a[9:5] == 5'h00) && (a[1:0] == 2'b00);
    end
  endfunction

  // crystal synchroniser and edge detect
  reg                 xtal_meta;
  reg                 xtal_sync;
  reg                 xtal_prev;
  wire                tick;

  // counter and registers
  reg [`CNT_W-1:0]    count;
  reg [`SEC_W-1:0]    sec_pre;
  reg [`FRAC_W-1:0]   frac_pre;
  reg                 run_en;
  reg                 load_req;
  reg                 alarm_en;
  reg [`SEC_W-1:0]    alarm_sec;
  reg                 alarm_flag;
  reg [TRIM_W-1:0]    trim_ivl;
  reg                 trim_add;
  reg                 trim_on;
  reg [TRIM_W-1:0]    trim_cnt;

  // bus decode
  wire                setup_rd;
  wire                wr_acc;
  wire                wr_reg;
  wire                wr_ram;
  wire [31:0]         ram_rdata;

  // next values
  reg [`CNT_W-1:0]    next_count;
  reg [TRIM_W-1:0]    next_trim_cnt;
  reg                 next_load_req;
  reg                 next_alarm_flag;
  reg [31:0]          next_prdata;
  reg                 next_pslverr;
  reg                 trim_due;
  reg                 alarm_hit;

  // two flops before any logic looks at the crystal clock
  always @(posedge clk) begin
    if (!rst_n) begin
      xtal_meta <= 1'b0;
      xtal_sync <= 1'b0;
      xtal_prev <= 1'b0;
    end else begin
      xtal_meta <= xtal_32k;
      xtal_sync <= xtal_meta;
      xtal_prev <= xtal_sync;
    end
  end

  // one pulse per crystal rising edge; clk must be well above 65 kHz
  assign tick = xtal_sync & ~xtal_prev;

  // apb phases: writes commit in the access phase, reads are fetched in setup
  assign setup_rd = psel & ~penable & ~pwrite;
  assign wr_acc   = psel & penable & pwrite & pready;
  assign wr_reg   = wr_acc & is_reg(paddr);
  assign wr_ram   = wr_acc & is_ram(paddr);

  // trim interval scheduling
  always @* begin
    trim_due      = 1'b0;
    next_trim_cnt = trim_cnt;
    if (trim_on && (trim_ivl != `RST_TRIM) && tick && run_en) begin
      if (trim_cnt >= trim_ivl - 1'b1) begin
        trim_due      = 1'b1;
        next_trim_cnt = `RST_TRIM;
      end else begin
        next_trim_cnt = trim_cnt + 1'b1;
      end
    end
    if (!trim_on) begin
      next_trim_cnt = `RST_TRIM;
    end
  end

  // counter next value; a load waits for a cycle with no tick so that the
  // tick is neither merged into the loaded value nor counted twice
  always @* begin
    next_count    = count;
    next_load_req = load_req;
    if (load_req && !tick) begin
      next_count    = {sec_pre, frac_pre};
      next_load_req = 1'b0;
    end else if (run_en && tick) begin
      if (trim_due && trim_add) begin
        next_count = count + `INC_ADD;
      end else if (trim_due) begin
        next_count = count + `INC_SKIP;
      end else begin
        next_count = count + `INC_NORMAL;
      end
    end
    // software setting the bit in the same cycle wins over the self-clear
    if (wr_reg && (paddr == `OFS_CONTROL) && pwdata[`CTL_LOAD]) begin
      next_load_req = 1'b1;
    end
  end

  // alarm fires on entry into the programmed second, not while parked there
  always @* begin
    alarm_hit = alarm_en
              && (next_count[`SEC_MSB:`SEC_LSB] == alarm_sec)
              && (count[`SEC_MSB:`SEC_LSB] != alarm_sec);
    next_alarm_flag = alarm_flag;
    if (wr_reg && (paddr == `OFS_STATUS) && pwdata[`STS_ALARM]) begin
      next_alarm_flag = 1'b0;
    end
    if (alarm_hit) begin
      next_alarm_flag = 1'b1;
    end
  end

  // counter state; runs regardless of bus activity
  always @(posedge clk) begin
    if (!rst_n) begin
      count    <= `RST_COUNT;
      load_req <= 1'b0;
      trim_cnt <= `RST_TRIM;
    end else begin
      count    <= next_count;
      load_req <= next_load_req;
      trim_cnt <= next_trim_cnt;
    end
  end

  // software-written registers
  always @(posedge clk) begin
    if (!rst_n) begin
      sec_pre   <= `RST_WORD;
      frac_pre  <= {`FRAC_W{1'b0}};
      run_en    <= 1'b0;
      alarm_en  <= 1'b0;
      alarm_sec <= `RST_WORD;
      trim_ivl  <= `RST_TRIM;
      trim_add  <= 1'b0;
      trim_on   <= 1'b0;
    end else if (wr_reg) begin
      case (paddr)
        `OFS_SEC_PRE: begin
          sec_pre <= pwdata;
        end
        `OFS_FRAC_PRE: begin
          frac_pre <= pwdata[`FRAC_MSB:0];
        end
        `OFS_CONTROL: begin
          run_en   <= pwdata[`CTL_ENABLE];
          alarm_en <= pwdata[`CTL_ALARM_EN];
        end
        `OFS_ALARM: begin
          alarm_sec <= pwdata;
        end
        `OFS_TRIM: begin
          trim_ivl <= pwdata[`TRIM_IVL_MSB:0];
          trim_add <= pwdata[`TRIM_ADD];
          trim_on  <= pwdata[`TRIM_EN];
        end
        default: begin
          run_en <= run_en;
        end
      endcase
    end
  end

  // sticky alarm flag and wake request
  always @(posedge clk) begin
    if (!rst_n) begin
      alarm_flag <= 1'b0;
      wake_req   <= 1'b0;
    end else begin
      alarm_flag <= next_alarm_flag;
      wake_req   <= next_alarm_flag;
    end
  end

  // read mux, evaluated in the setup phase so prdata is a flop output
  always @* begin
    next_prdata  = `RST_WORD;
    next_pslverr = 1'b0;
    if (is_ram(paddr)) begin
      next_prdata = ram_rdata;
    end else if (is_reg(paddr)) begin
      case (paddr)
        `OFS_SECONDS: begin
          next_prdata = count[`SEC_MSB:`SEC_LSB];
        end
        `OFS_FRACTION: begin
          next_prdata = {17'h00000, count[`FRAC_MSB:0]};
        end
        `OFS_SEC_PRE: begin
          next_prdata = sec_pre;
        end
        `OFS_FRAC_PRE: begin
          next_prdata = {17'h00000, frac_pre};
        end
        `OFS_CONTROL: begin
          next_prdata = {29'h00000000, alarm_en, load_req, run_en};
        end
        `OFS_ALARM: begin
          next_prdata = alarm_sec;
        end
        `OFS_STATUS: begin
          next_prdata = {31'h00000000, alarm_flag};
        end
        `OFS_TRIM: begin
          next_prdata = {14'h0000, trim_on, trim_add, trim_ivl};
        end
        default: begin
          next_prdata = `RST_WORD;
        end
      endcase
    end else begin
      next_pslverr = 1'b1;  // unmapped address
    end
  end

  // apb answer: one access cycle, ready always in the first one
  always @(posedge clk) begin
    if (!rst_n) begin
      prdata  <= `RST_WORD;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & next_pslverr;
      if (setup_rd) begin
        prdata <= next_prdata;
      end else begin
        prdata <= `RST_WORD;
      end
    end
  end

  // retained memory behind the bus window
  backup_ram #(
    .DEPTH (`RAM_DEPTH),
    .IDX_W (`RAM_IDX_W)
  ) u_ram (
    .clk   (clk),
    .we    (wr_ram),
    .waddr (paddr[7:2]),
    .wdata (pwdata),
    .raddr (paddr[7:2]),
    .rdata (ram_rdata)
  );

endmodule

// >>> backup_seconds_counter_asserts.sv
// assertion checker for the backup seconds counter ports
`timescale 1ns/1ns
`include "backup_seconds_counter_consts.vh"
module backup_seconds_counter_asserts (
  // clock and reset
  input wire        clk,
  input wire        rst_n,
  input wire        xtal_32k,
  // apb slave
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [9:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // wake-up
  input wire        wake_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // bus phases: setup used by several properties, write-one clear by p_clr only
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_w1c;
    psel && penable && pwrite && pready && paddr == `OFS_STATUS && pwdata[0];
  endsequence
  property p_ready; s_setup |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("ready too long");
  property p_err;
    s_setup ##0 (paddr[9:8] == 2'h0 && paddr[7:5] != 3'h0) |=> pslverr;
  endproperty
  a_err: assert property (p_err) else $error("no error");
  property p_ok; s_setup ##0 paddr == `OFS_SECONDS |=> !pslverr; endproperty
  a_ok: assert property (p_ok) else $error("false error");
  property p_rst; $rose(rst_n) |-> !pready && !wake_req; endproperty
  a_rst: assert property (p_rst) else $error("busy after reset");
  property p_idle; !pready |-> prdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("stray read data");
  property p_frac;
    pready && !pwrite && (paddr == `OFS_FRACTION || paddr == `OFS_FRAC_PRE)
      |-> prdata[31:15] == 17'h0;
  endproperty
  a_frac: assert property (p_frac) else $error("fraction too wide");
  property p_clr; s_w1c |=> ##1 !wake_req; endproperty
  a_clr: assert property (p_clr) else $error("wake not cleared");
endmodule

bind backup_seconds_counter backup_seconds_counter_asserts u_chk (
  .clk(clk), .rst_n(rst_n), .xtal_32k(xtal_32k), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .wake_req(wake_req));

// >>> backup_seconds_counter_consts.vh
// constants for the backup-domain seconds counter and its register map
`ifndef BACKUP_SECONDS_COUNTER_CONSTS_VH
`define BACKUP_SECONDS_COUNTER_CONSTS_VH

// counter layout
`define CNT_W          47
`define SEC_W          32
`define FRAC_W         15
`define SEC_MSB        46
`define SEC_LSB        15
`define FRAC_MSB       14

// register byte offsets (word aligned)
`define OFS_SECONDS    10'h000
`define OFS_FRACTION   10'h004
`define OFS_SEC_PRE    10'h008
`define OFS_FRAC_PRE   10'h00c
`define OFS_CONTROL    10'h010
`define OFS_ALARM      10'h014
`define OFS_STATUS     10'h018
`define OFS_TRIM       10'h01c

// backup memory window: 0x100..0x1ff, 64 words of 4 bytes
`define RAM_BASE_BIT   8
`define RAM_IDX_W      6
`define RAM_DEPTH      64

// control fields
`define CTL_ENABLE     0
`define CTL_LOAD       1
`define CTL_ALARM_EN   2

// status fields
`define STS_ALARM      0

// trim fields
`define TRIM_IVL_MSB   15
`define TRIM_ADD       16
`define TRIM_EN        17
`define TRIM_W         16

// reset values
`define RST_WORD       32'h00000000
`define RST_COUNT      47'h000000000000
`define RST_TRIM       16'h0000

// increments applied per 32 kHz tick
`define INC_NORMAL     47'h000000000001
`define INC_ADD        47'h000000000002
`define INC_SKIP       47'h000000000000

`endif

// >>> backup_seconds_counter_tb_top.sv
// self-checking testbench for the backup seconds counter
`timescale 1ns/1ns
`include "backup_seconds_counter_consts.vh"
module backup_seconds_counter_tb_top;
  logic        clk, rst_n, xtal_32k, psel, penable, pwrite;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata, v, s, f;
  logic        pready, pslverr, wake_req;
  logic [64:0] note_q[$];
  logic [64:0] nt;
  logic [9:0]  bad[4] = '{10'h020, 10'h0fc, 10'h002, 10'h200};
  int          error_cnt, n_checks, k;

  backup_seconds_counter dut (.clk(clk), .rst_n(rst_n), .xtal_32k(xtal_32k),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wake_req(wake_req));

  // system clock, then an unrelated crystal clock
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  initial begin
    xtal_32k = 0;
    #7;
    forever #15259 xtal_32k = ~xtal_32k;
  end

  task automatic fail(input string m);
    error_cnt++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) fail(m);
  endtask
  task automatic complete_run;
    $display("errors %0d checks %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // one apb access; the note holds expected error, mask and data
  task automatic acc(input logic w, input logic [9:0] a,
                     input logic [31:0] d, m, e, input logic er);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    note_q.push_back({er, m, e});
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    v = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // load with polling; the bit must drop on its own
  task automatic load(input logic [31:0] c);
    acc(1, `OFS_CONTROL, c | 32'h2, '0, '0, 0);
    for (k = 0; k < 8; k++) begin
      acc(0, `OFS_CONTROL, '0, '0, '0, 0);
      if (v[1] === 1'b0) break;
    end
    chk(v[1] === 1'b0, "load bit stuck");
  endtask
  // stop the count and let the synchroniser settle
  task automatic halt;
    acc(1, `OFS_CONTROL, '0, '0, '0, 0);
    repeat (5) @(posedge clk);
  endtask

  // watcher: every answer retires the oldest note
  always @(posedge clk) begin
    if (rst_n === 1'b1 && pready === 1'b1) begin
      if (note_q.size() == 0) fail("unexpected answer");
      else begin
        nt = note_q.pop_front();
        n_checks++;
        if (pslverr !== nt[64] || (prdata & nt[63:32]) !== nt[31:0])
          fail("answer mismatch");
      end
    end
  end

  // a hang ends the run through the same report
  initial begin
    repeat (100000) @(posedge clk);
    fail("timeout");
    complete_run;
  end

  initial begin
    {rst_n, psel, penable, pwrite} = 4'h0;
    paddr = '0;
    pwdata = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    k = $urandom(27);
    acc(0, `OFS_CONTROL, '0, '1, '0, 0);
    acc(0, `OFS_SECONDS, '0, '1, '0, 0);
    acc(0, `OFS_STATUS, '0, '1, '0, 0);
    foreach (bad[i]) begin
      acc(1, bad[i], '1, '0, '0, 1);
      acc(0, bad[i], '0, '1, '0, 1);
    end
    // preloads, then an atomic load while stopped
    s = $urandom;
    f = $urandom & 32'h3fff;
    acc(1, `OFS_SEC_PRE, s, '0, '0, 0);
    acc(1, `OFS_FRAC_PRE, f | 32'hffff8000, '0, '0, 0);
    acc(0, `OFS_SEC_PRE, '0, '1, s, 0);
    acc(0, `OFS_FRAC_PRE, '0, '1, f, 0);
    load('0);
    acc(0, `OFS_SECONDS, '0, '1, s, 0);
    acc(0, `OFS_FRACTION, '0, '1, f, 0);
    // count ten ticks, stop, and see the count hold
    acc(1, `OFS_CONTROL, 32'h1, '0, '0, 0);
    repeat (10) @(posedge xtal_32k);
    halt;
    acc(0, `OFS_FRACTION, '0, '0, '0, 0);
    chk(v - f >= 10 && v - f <= 11, "count rate");
    repeat (2) @(posedge xtal_32k);
    acc(0, `OFS_FRACTION, '0, '1, v, 0);
    // trim: skip each tick, add each tick, then skip every second tick;
    // one tick may slip in while the load settles, hence the ranges
    for (int md = 0; md < 3; md++) begin
      v = (md == 2) ? 32'h20002 : (32'h20001 | (md << 16));
      acc(1, `OFS_TRIM, v, '0, '0, 0);
      acc(1, `OFS_FRAC_PRE, '0, '0, '0, 0);
      load(32'h1);
      repeat (6) @(posedge xtal_32k);
      halt;
      acc(0, `OFS_FRACTION, '0, '0, '0, 0);
      chk(md != 0 || v === 0, "trim skip");
      chk(md != 1 || (v >= 12 && v <= 14), "trim add");
      chk(md != 2 || (v >= 3 && v <= 4), "trim interval");
      acc(0, `OFS_SECONDS, '0, '1, s, 0);
    end
    acc(1, `OFS_TRIM, '0, '0, '0, 0);
    // alarm on entry into second six, then write-one clear
    acc(1, `OFS_SEC_PRE, 32'h5, '0, '0, 0);
    acc(1, `OFS_FRAC_PRE, 32'h7ff0, '0, '0, 0);
    acc(1, `OFS_ALARM, 32'h6, '0, '0, 0);
    load(32'h5);
    for (k = 0; k < 9000 && wake_req !== 1'b1; k++) @(posedge clk);
    chk(wake_req === 1'b1, "no wake");
    halt;
    acc(0, `OFS_SECONDS, '0, '1, 32'h6, 0);
    acc(0, `OFS_STATUS, '0, 32'h1, 32'h1, 0);
    acc(1, `OFS_STATUS, 32'h1, '0, '0, 0);
    acc(0, `OFS_STATUS, '0, 32'h1, '0, 0);
    chk(wake_req === 1'b0, "wake stays");
    // same crossing with the alarm disabled must stay quiet
    load(32'h1);
    repeat (6000) @(posedge clk);
    halt;
    acc(0, `OFS_SECONDS, '0, '1, 32'h6, 0);
    acc(0, `OFS_STATUS, '0, 32'h1, '0, 0);
    chk(wake_req === 1'b0, "wake while disabled");
    // retained memory at both ends of its window
    s = $urandom;
    f = $urandom;
    acc(1, 10'h100, s, '0, '0, 0);
    acc(1, 10'h1fc, f, '0, '0, 0);
    acc(0, 10'h100, '0, '1, s, 0);
    acc(0, 10'h1fc, '0, '1, f, 0);
    repeat (2) @(posedge clk);
    chk(note_q.size() == 0, "missing answer");
    complete_run;
  end
endmodule
